// *** rtl/hpd_sequencer.sv ***
// Purpose: hardware power-down entry and wake-up sequencing
// Assumes: cpu core supplies instruction strobes, latch pulses and isr status
// Notes: oscillator stop is a request; the core honours cpu_run low as a freeze
`timescale 1ns/1ps
`include "hpd_map.svh"
`default_nettype none
module hpd_sequencer
   import hpd_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   input  wire logic        power_hold_pin,
   input  wire logic        reset_pin_n,
   input  wire logic        irq_pin_n,
   input  wire logic        irq_enable_op,
   input  wire logic        irq_disable_op,
   input  wire logic        in_isr,
   input  wire logic        clk_out_enabled,
   input  wire logic        ale_pulse,
   output logic             osc_enable,
   output logic             cpu_run,
   output logic             cpu_reset,
   output logic             take_irq,
   output logic [11:0]      resume_vector,
   output logic             resume_valid,
   output logic             pins_float,
   output logic             first_test_pin_float,
   output logic             irq_enabled
);

   // synchronised pin levels: bit 0 power hold, bit 1 reset, bit 2 interrupt
   logic [2:0]              pin_raw;
   logic [2:0]              pin_level;
   logic                    ph_reg;
   logic                    rst_n_reg;
   logic                    irq_n_reg;

   hpd_state_e              state_reg;
   hpd_state_e              state_next;
   hpd_resume_e             resume_reg;
   hpd_resume_e             resume_next;
   logic [`HPD_OSC_CNT_W-1:0] osc_cnt_reg;
   logic [`HPD_OSC_CNT_W-1:0] osc_cnt_next;
   logic [1:0]              ale_cnt_reg;
   logic [1:0]              ale_cnt_next;
   logic                    isr_at_down_reg;
   logic                    irq_en_reg;
   logic                    osc_done;
   logic                    ale_done;
   logic                    wake_rise;
   logic                    entering_down;
   logic                    irq_class;
   logic                    hold_reset;
   logic                    reset_at_end;
   logic                    irq_vector_now;
   logic                    leaving_irq;
   logic                    osc_enable_next;
   logic                    cpu_run_next;
   logic                    cpu_reset_next;
   logic                    resume_valid_next;
   logic                    pins_float_next;
   logic                    tp_float_next;
   logic [11:0]             resume_vector_next;

   // three-flop chains; a level counts only when stages two and three agree
   // chains reset high so the idle pin level gives no false edge after reset
   assign pin_raw = {irq_pin_n, reset_pin_n, power_hold_pin};

   generate
      for (genvar g = 0; g < 3; g++) begin : g_sync
         logic [2:0] sync_reg;
         logic       level_reg;

         always_ff @(posedge sys_clk) begin
            if (!nrst) begin
               sync_reg  <= 3'h7;
               level_reg <= 1'b1;
            end else begin
               sync_reg <= {sync_reg[1:0], pin_raw[g]};
               if (sync_reg[2] == sync_reg[1])
                  level_reg <= sync_reg[2];
            end
         end

         assign pin_level[g] = level_reg;
      end
   endgenerate

   assign ph_reg    = pin_level[0];
   assign rst_n_reg = pin_level[1];
   assign irq_n_reg = pin_level[2];

   assign entering_down = (state_reg == HPD_RUN) && !ph_reg;
   assign wake_rise     = (state_reg == HPD_DOWN) && ph_reg;
   assign osc_done      = (osc_cnt_reg == `HPD_OSC_CNT_W'(`HPD_OSC_CYCLES - 1));
   assign ale_done      = (ale_cnt_reg >= `HPD_ALE_MIN);
   // interrupt-pin wakes wait for latch pulses only while the pin stays low
   assign irq_class     = (resume_reg == HPD_RES_VECTOR) || (resume_reg == HPD_RES_CONTINUE);

   // enable flop: disable op wins if both strobes collide
   always_ff @(posedge sys_clk) begin
      if (!nrst)
         irq_en_reg <= 1'b0;              // see RULE6
      else if (irq_disable_op)
         irq_en_reg <= 1'b0;              // see RULE6
      else if (irq_enable_op)
         irq_en_reg <= 1'b1;              // see RULE6
   end

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         HPD_RUN: begin
            if (!ph_reg)
               state_next = HPD_DOWN;                              // see RULE9
         end
         HPD_DOWN: begin
            if (wake_rise)
               state_next = HPD_OSC_WAIT;
         end
         HPD_OSC_WAIT: begin
            // a power-hold drop during the settle wait goes straight back down
            if (!ph_reg)
               state_next = HPD_DOWN;
            else if (osc_done && irq_class && !irq_n_reg)
               state_next = HPD_IRQ_WAIT;
            else if (osc_done)
               state_next = HPD_RUN;
         end
         HPD_IRQ_WAIT: begin
            if (!ph_reg)
               state_next = HPD_DOWN;
            else if (ale_done || irq_n_reg)
               state_next = HPD_RUN;
         end
         default: state_next = HPD_RUN;
      endcase
   end

   // wake class is chosen once, at the synchronised power-hold rise
   always_comb begin
      resume_next = resume_reg;
      if (wake_rise) begin
         if (!rst_n_reg)
            resume_next = HPD_RES_RESET;                          // see RULE1, see RULE11
         else if (!irq_n_reg && irq_en_reg && !isr_at_down_reg)
            resume_next = HPD_RES_VECTOR;                         // see RULE2
         else if (!irq_n_reg)
            resume_next = HPD_RES_CONTINUE;                       // see RULE3, see RULE4
         else
            resume_next = HPD_RES_NONE;                           // see RULE5
      end
   end

   assign osc_cnt_next = (state_reg == HPD_OSC_WAIT && !osc_done) ?
                         osc_cnt_reg + 1'b1 : '0;
   assign ale_cnt_next = (state_reg != HPD_IRQ_WAIT) ? 2'h0 :
                         (ale_pulse && !ale_done) ? ale_cnt_reg + 1'b1 :
                         ale_cnt_reg;                             // see RULE2, see RULE4

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         state_reg  <= HPD_RUN;
         resume_reg <= HPD_RES_NONE;
      end else begin
         state_reg  <= state_next;
         resume_reg <= resume_next;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         osc_cnt_reg <= '0;
         ale_cnt_reg <= 2'h0;
      end else begin
         osc_cnt_reg <= osc_cnt_next;
         ale_cnt_reg <= ale_cnt_next;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst)
         isr_at_down_reg <= 1'b0;
      else if (entering_down)
         isr_at_down_reg <= in_isr;                                // see RULE3
   end

   // reset wake keeps cpu in reset through the whole oscillator settle and no longer, even if the reset pin is still low
   assign hold_reset     = (resume_reg == HPD_RES_RESET) && (state_reg == HPD_OSC_WAIT);
   assign reset_at_end   = hold_reset && (state_next == HPD_RUN) && !rst_n_reg;
   assign leaving_irq    = (state_reg == HPD_IRQ_WAIT) && (state_next == HPD_RUN) && ale_done;
   assign irq_vector_now = leaving_irq && (resume_reg == HPD_RES_VECTOR);

   assign osc_enable_next    = (state_next != HPD_DOWN);                 // see RULE9
   // cpu frozen, not reset, while powered down, so registers and ram survive
   assign cpu_run_next       = (state_next == HPD_RUN);                  // see RULE10
   assign cpu_reset_next     = hold_reset || reset_at_end;               // see RULE1
   assign resume_valid_next  = (state_reg != HPD_RUN) && (state_next == HPD_RUN);
   assign pins_float_next    = (state_next == HPD_DOWN);                 // see RULE7
   assign tp_float_next      = pins_float_next && clk_out_enabled;       // see RULE8
   assign resume_vector_next = irq_vector_now ? `HPD_IRQ_VECTOR :
                               (resume_reg == HPD_RES_RESET) ? `HPD_RESET_VECTOR :
                               resume_vector;

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         osc_enable           <= 1'b1;
         cpu_run              <= 1'b1;
         pins_float           <= 1'b0;
         first_test_pin_float <= 1'b0;
      end else begin
         osc_enable           <= osc_enable_next;
         cpu_run              <= cpu_run_next;
         pins_float           <= pins_float_next;
         first_test_pin_float <= tp_float_next;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         cpu_reset    <= 1'b0;
         take_irq     <= 1'b0;
         resume_valid <= 1'b0;
      end else begin
         cpu_reset    <= cpu_reset_next;
         take_irq     <= irq_vector_now;                           // see RULE2
         resume_valid <= resume_valid_next;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         resume_vector <= `HPD_RESET_VECTOR;
         irq_enabled   <= 1'b0;
      end else begin
         resume_vector <= resume_vector_next;
         irq_enabled   <= irq_en_reg;                              // see RULE6
      end
   end
endmodule : hpd_sequencer
`default_nettype wire

// *** rtl/hpd_map.svh ***
// Purpose: constants for the hardware power-down and wake-up sequencer
// Assumes: one 200 MHz clock, synchronous active-low reset
// Notes: pin levels are sampled through three flops before use
// What this block does
// RULE1: a power-hold rise with reset low restarts the oscillator and, once it is stable, resets the cpu to address 0.
// RULE2: a power-hold rise with the interrupt pin low and interrupts enabled restarts the clock and, after 2 latch pulses, vectors to address 3.
// RULE3: a wake by the interrupt pin during an interrupt routine does not vector again but resumes at the next instruction.
// RULE4: with interrupts disabled, an interrupt-pin wake held for 2 latch pulses resumes at the next instruction with no interrupt.
// RULE5: a power-hold rise with reset and interrupt both high resumes exactly where execution stopped.
// RULE6: the external interrupt is disabled by the disable instruction or reset and enabled only by the enable instruction.
// RULE7: in power-down the bus, both ports and all strobes float while crystal, reset, interrupt, access and second test pin stay active.
// RULE8: in power-down the first test pin floats only if its clock output was enabled.
// RULE9: a low power-hold pin stops the oscillator and floats the i/o pins in either memory mode.
// RULE10: on entering power-down the cpu halts with all internal state kept.
// RULE11: with reset and interrupt both low at wake, reset wins and a full reset is done.
`ifndef HPD_MAP_SVH
`define HPD_MAP_SVH
`define HPD_RESET_VECTOR   12'h000
`define HPD_IRQ_VECTOR     12'h003
`define HPD_ALE_MIN        2'h2
`define HPD_OSC_STABLE_US  10
`define HPD_OSC_CYCLES     (`HPD_OSC_STABLE_US * 200)
`define HPD_OSC_CNT_W      12
`endif

// *** rtl/hpd_pkg.sv ***
// Purpose: types for the power-down sequencer
// Assumes: nothing beyond the map header
// Notes: none
`default_nettype none
package hpd_pkg;
   typedef enum logic [2:0] {
      HPD_RUN,
      HPD_DOWN,
      HPD_OSC_WAIT,
      HPD_IRQ_WAIT
   } hpd_state_e;
   typedef enum logic [1:0] {
      HPD_RES_NONE,
      HPD_RES_RESET,
      HPD_RES_VECTOR,
      HPD_RES_CONTINUE
   } hpd_resume_e;
endpackage : hpd_pkg
`default_nettype wire

// *** testbench/hpd_core_model.sv ***
// Purpose: core stand-in that gives address latch pulses
// Assumes: no latch pulses while the oscillator is stopped
// Notes: one pulse every fourth cycle, slower than any real core
`timescale 1ns/1ps
`default_nettype none
module hpd_core_model (
   input  wire logic sys_clk,
   input  wire logic osc_enable,
   output var  logic ale_pulse
);
   logic [1:0] div_reg = 2'h0;
   initial ale_pulse = 1'h0;
   always @(posedge sys_clk) begin
      div_reg <= osc_enable ? div_reg + 2'h1 : 2'h0;
      ale_pulse <= osc_enable && (div_reg == 2'h3);
   end
endmodule : hpd_core_model
`default_nettype wire

// *** testbench/hpd_sequencer_sva.sv ***
// Purpose: port checks for the power-down sequencer
// Assumes: clk_out_enabled held steady while pins float
// Notes: bound to every sequencer instance
`timescale 1ns/1ps
`include "hpd_map.svh"
`default_nettype none
module hpd_sequencer_sva (
   input wire logic        sys_clk,
   input wire logic        nrst,
   input wire logic        irq_enable_op,
   input wire logic        irq_disable_op,
   input wire logic        clk_out_enabled,
   input wire logic        osc_enable,
   input wire logic        cpu_run,
   input wire logic        take_irq,
   input wire logic [11:0] resume_vector,
   input wire logic        resume_valid,
   input wire logic        pins_float,
   input wire logic        first_test_pin_float,
   input wire logic        irq_enabled
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   sequence s_wake; $rose(osc_enable) && !cpu_run; endsequence
   sequence s_settle; (!resume_valid && !cpu_run) [*8]; endsequence
   float_halts_a: assert property (pins_float |-> !osc_enable && !cpu_run && !take_irq)
      else $error("pins float while running");
   settle_wait_a: assert property (s_wake |-> s_settle)
      else $error("resume before oscillator settled");
   tp_float_a: assert property (first_test_pin_float |-> pins_float && clk_out_enabled)
      else $error("test pin floats wrongly");
   tp_follow_a: assert property (pins_float |-> first_test_pin_float == clk_out_enabled)
      else $error("test pin float does not follow clock output");
   irq_vector_a: assert property (take_irq |-> resume_vector == `HPD_IRQ_VECTOR && irq_enabled)
      else $error("bad interrupt vector");
   resume_pulse_a: assert property (resume_valid |=> !resume_valid && !pins_float)
      else $error("resume not a single pulse");
   irq_off_a: assert property (irq_disable_op |-> ##2 !irq_enabled)
      else $error("interrupt still enabled");
   irq_on_a: assert property (irq_enable_op && !irq_disable_op |-> ##2 irq_enabled)
      else $error("interrupt not enabled");
endmodule : hpd_sequencer_sva
bind hpd_sequencer hpd_sequencer_sva i_hpd_sequencer_sva (.sys_clk, .nrst, .irq_enable_op,
   .irq_disable_op, .clk_out_enabled, .osc_enable, .cpu_run, .take_irq, .resume_vector,
   .resume_valid, .pins_float, .first_test_pin_float, .irq_enabled);
`default_nettype wire

// *** testbench/hpd_sequencer_test.sv ***
// Purpose: self-checking bench for the power-down sequencer
// Assumes: oscillator settle of 2000 cycles from the map header
// Notes: row bits are reset, irq, enable, isr, clock out, expect irq, expect reset
`timescale 1ns/1ps
`include "hpd_map.svh"
`default_nettype none
module hpd_sequencer_test;
   logic sys_clk = 1'h0, nrst, power_hold_pin, reset_pin_n, irq_pin_n, irq_enable_op;
   logic irq_disable_op, in_isr, clk_out_enabled, ale_pulse, osc_enable, cpu_run, cpu_reset;
   logic take_irq, resume_valid, pins_float, first_test_pin_float, irq_enabled, si, sr;
   logic [11:0] resume_vector, vec;
   logic [6:0] r;
   int mismatches = 0, num_checks = 0, nv;
   logic [6:0] rows [6] = '{7'h21, 7'h56, 7'h58, 7'h40, 7'h74, 7'h11};
   always #2.5 sys_clk = ~sys_clk;
   hpd_sequencer i_hpd_sequencer (
      .sys_clk              (sys_clk),
      .nrst                 (nrst),
      .power_hold_pin       (power_hold_pin),
      .reset_pin_n          (reset_pin_n),
      .irq_pin_n            (irq_pin_n),
      .irq_enable_op        (irq_enable_op),
      .irq_disable_op       (irq_disable_op),
      .in_isr               (in_isr),
      .clk_out_enabled      (clk_out_enabled),
      .ale_pulse            (ale_pulse),
      .osc_enable           (osc_enable),
      .cpu_run              (cpu_run),
      .cpu_reset            (cpu_reset),
      .take_irq             (take_irq),
      .resume_vector        (resume_vector),
      .resume_valid         (resume_valid),
      .pins_float           (pins_float),
      .first_test_pin_float (first_test_pin_float),
      .irq_enabled          (irq_enabled)
   );
   hpd_core_model i_hpd_core_model (.sys_clk(sys_clk), .osc_enable(osc_enable), .ale_pulse(ale_pulse));
   task automatic conclude;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : conclude
   task automatic chk(input logic ok, input string m);
      num_checks++;
      if (ok !== 1'h1) begin
         mismatches++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask : chk
   task automatic wait_float(input int n);
      while (pins_float !== 1'h1) begin
         @(posedge sys_clk);
         if (--n == 0) begin
            mismatches++;
            conclude();
         end
      end
   endtask : wait_float
   initial begin
      {nrst, irq_enable_op, irq_disable_op, in_isr, clk_out_enabled} = 5'h0;
      {power_hold_pin, reset_pin_n, irq_pin_n} = 3'h7;
      repeat (5) @(posedge sys_clk);
      nrst <= 1'h1;
      repeat (4) @(posedge sys_clk);
      chk(osc_enable === 1'h1 && cpu_run === 1'h1 && irq_enabled === 1'h0, "reset");
      foreach (rows[i]) begin
         r = rows[i];
         irq_enable_op <= r[4];
         irq_disable_op <= !r[4];
         in_isr <= r[3];
         clk_out_enabled <= r[2];
         @(posedge sys_clk);
         {irq_enable_op, irq_disable_op, power_hold_pin} <= 3'h0;
         wait_float(20);
         repeat (3) @(posedge sys_clk);
         chk(!osc_enable && !cpu_run && first_test_pin_float === r[2], "float");
         chk(irq_enabled === r[4], "enable");
         reset_pin_n <= r[6];
         irq_pin_n <= r[5];
         repeat (4) @(posedge sys_clk);
         power_hold_pin <= 1'h1;
         {si, sr} = 2'h0;
         nv = 0;
         repeat (2200) begin
            @(posedge sys_clk);
            if (take_irq === 1'h1) {si, vec} = {1'h1, resume_vector};
            if (cpu_reset === 1'h1) sr = 1'h1;
            if (resume_valid === 1'h1) nv++;
         end
         chk(nv == 1, "resume pulse");
         if (r[0]) chk(resume_vector === `HPD_RESET_VECTOR, "reset vector");
         chk(si === r[1] && sr === r[0] && cpu_run === 1'h1, "wake");
         if (r[1]) chk(vec === `HPD_IRQ_VECTOR, "vector");
         {reset_pin_n, irq_pin_n} <= 2'h3;
         repeat (10) @(posedge sys_clk);
      end
      // wake cut short: power hold drops again during the settle wait
      power_hold_pin <= 1'h0;
      wait_float(20);
      power_hold_pin <= 1'h1;
      repeat (30) @(posedge sys_clk);
      chk(osc_enable === 1'h1 && cpu_run === 1'h0, "settle");
      power_hold_pin <= 1'h0;
      wait_float(20);
      chk(osc_enable === 1'h0 && cpu_run === 1'h0, "refused");
      // reset in mid-run while powered down
      nrst <= 1'h0;
      repeat (5) @(posedge sys_clk);
      nrst <= 1'h1;
      repeat (2) @(posedge sys_clk);
      chk(osc_enable === 1'h1 && pins_float === 1'h0 && irq_enabled === 1'h0, "mid reset");
      wait_float(20);
      power_hold_pin <= 1'h1;
      repeat (2100) @(posedge sys_clk);
      chk(cpu_run === 1'h1 && pins_float === 1'h0 && take_irq === 1'h0, "resume");
      conclude();
   end
endmodule : hpd_sequencer_test
`default_nettype wire
